/* shared/sbsa_regs.svh */
// Constants for the synchronous burst SRAM access core
`ifndef SBSA_REGS_SVH
`define SBSA_REGS_SVH

`define SBSA_ADDR_W      18
`define SBSA_LANES       4
`define SBSA_LANE_W      8
`define SBSA_DATA_W      32
`define SBSA_WORD_W      36
`define SBSA_BURST_W     2
`define SBSA_BW_NONE     4'hf
`define SBSA_BEAT_FIRST  2'h0
`define SBSA_BEAT_STEP   2'h1
`define SBSA_WBUF_DEPTH  8

`endif

/* shared/sbsa_pkg.sv */
// Types shared by the burst SRAM access core and its buffer
`default_nettype none
`include "sbsa_regs.svh"
package sbsa_pkg;

  typedef enum logic [1:0] {
    SBSA_DESEL = 2'h0,
    SBSA_READ  = 2'h1,
    SBSA_WRITE = 2'h3
  } sbsa_phase_t;

  typedef struct packed {
    logic [`SBSA_ADDR_W-1:0] addr;
    logic [`SBSA_LANES-1:0]  bw;
    logic [`SBSA_DATA_W-1:0] data;
    logic [`SBSA_LANES-1:0]  par;
  } sbsa_beat_t;

  typedef struct packed {
    logic                     sleep_s1;
    logic                     sleep_s2;
    logic                     mode_s1;
    logic                     mode_s2;
    sbsa_phase_t              phase;
    logic [`SBSA_ADDR_W-1:0]  base;
    logic [`SBSA_BURST_W-1:0] beat;
    logic                     wr_pend;
    logic [`SBSA_ADDR_W-1:0]  wr_addr;
    logic [`SBSA_LANES-1:0]   wr_bw;
    logic                     rd_drive;
    logic [`SBSA_DATA_W-1:0]  rd_data;
    logic [`SBSA_LANES-1:0]   rd_par;
  } sbsa_state_t;

endpackage : sbsa_pkg
`default_nettype wire

/* logic/sbsa_burst_order.sv */
// Burst beat address generator, linear or interleaved
`default_nettype none
module sbsa_burst_order #(
  parameter int unsigned LO_W = 2
) (
  input  wire logic [LO_W-1:0] start_lo,
  input  wire logic [LO_W-1:0] beat,
  input  wire logic            interleave,
  output logic      [LO_W-1:0] lo
);

  // Both orders wrap inside the low bits only
  always_comb begin
    if (interleave) begin
      lo = start_lo ^ beat;
    end else begin
      lo = LO_W'(start_lo + beat);
    end
  end

endmodule : sbsa_burst_order
`default_nettype wire

/* logic/sbsa_wbuf.sv */
// Write beat FIFO with valid and ready on both sides
`default_nettype none
module sbsa_wbuf #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0]   cnt;
  } sbsa_wptr_t;

  logic [WIDTH-1:0] slot [DEPTH];
  sbsa_wptr_t       st_r;
  sbsa_wptr_t       st_nxt;
  logic             push;
  logic             pop;

  function automatic logic [PW-1:0] sbsa_wrap(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : sbsa_wrap

  assign in_ready  = (st_r.cnt != (PW + 1)'(DEPTH));
  assign out_valid = (st_r.cnt != '0);
  assign out_data  = slot[st_r.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wr = sbsa_wrap(st_r.wr);
    end
    if (pop) begin
      st_nxt.rd = sbsa_wrap(st_r.rd);
    end
    if (push && !pop) begin
      st_nxt.cnt = (PW + 1)'(st_r.cnt + 1'b1);
    end else if (pop && !push) begin
      st_nxt.cnt = (PW + 1)'(st_r.cnt - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      slot[st_r.wr] <= in_data;
    end
  end

endmodule : sbsa_wbuf
`default_nettype wire

/* logic/sbsa_core.sv */
// Synchronous pipelined burst SRAM, device side, with byte writes and sleep
// Function
// - Load, all selects, strobe high: read
// - Advance in read: next address, drive
// - Read start, output enable high: tri-state
// - Read continue, enable high: advance, tri-state
// - Load, selects, strobe low, byte: write
// - Advance in write: next address, bytes
// - Write start without bytes: abort, nothing stored
// - Write continue without bytes: advance, nothing stored
// - Qualifier high, not asleep: edge ignored, state held
// - Write cycles keep all data pins released
// - Output enable gates pins without clocking
// - Drive only in reads with enable low
// - After reset: deselected, pins released
// - Strobe low, no bytes: memory unchanged
// - Each byte select writes lane plus parity
// - Inactive select at load deselects at once
// - Write data taken at following edge
// - Two-bit wrapping burst, linear or interleaved
// - Sleep in two cycles, inputs ignored
`default_nettype none
`include "sbsa_regs.svh"
module sbsa_core #(
  parameter int unsigned WBUF_DEPTH = `SBSA_WBUF_DEPTH
) (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    chip_select_low_first,
  input  wire logic                    chip_select_high_active,
  input  wire logic                    chip_select_low_second,
  input  wire logic                    advance_or_load,
  input  wire logic                    write_strobe_n,
  input  wire logic [`SBSA_LANES-1:0]  byte_write_select_n,
  input  wire logic                    clock_qualify_n,
  input  wire logic                    sleep_request,
  input  wire logic                    burst_order,
  input  wire logic                    out_enable_n,
  input  wire logic [`SBSA_ADDR_W-1:0] addr_in,
  input  wire logic [`SBSA_DATA_W-1:0] data_pins_in,
  input  wire logic [`SBSA_LANES-1:0]  parity_lane_pins_in,
  output logic      [`SBSA_DATA_W-1:0] data_pins_out,
  output logic      [`SBSA_LANES-1:0]  parity_lane_pins_out,
  output logic                         dq_oe_n
);

  localparam int unsigned DEPTH = 2 ** `SBSA_ADDR_W;

  sbsa_pkg::sbsa_state_t st_r;
  sbsa_pkg::sbsa_state_t st_nxt;

  logic [`SBSA_WORD_W-1:0]  mem [DEPTH];

  logic                     sleep_on;
  logic                     cs_all;
  logic                     edge_go;
  logic                     load_go;
  logic                     capture;
  logic                     bw_any;
  logic [`SBSA_BURST_W-1:0] beat_nxt;
  logic [`SBSA_BURST_W-1:0] lo_cont;
  logic [`SBSA_ADDR_W-1:0]  addr_cont;
  logic [`SBSA_ADDR_W-1:0]  rd_addr;
  logic [`SBSA_WORD_W-1:0]  rd_word;
  sbsa_pkg::sbsa_beat_t     beat_in;
  sbsa_pkg::sbsa_beat_t     wbuf_out;
  sbsa_pkg::sbsa_beat_t     mw_beat;
  logic                     wbuf_in_valid;
  logic                     wbuf_in_ready;
  logic                     wbuf_out_valid;
  logic                     wbuf_out_ready;
  logic                     mw_en;

  // Merge selected lanes of a beat over an old word, data plus parity
  function automatic logic [`SBSA_WORD_W-1:0] sbsa_merge(
    input logic [`SBSA_WORD_W-1:0] old_w,
    input sbsa_pkg::sbsa_beat_t    b
  );
    logic [`SBSA_WORD_W-1:0] w;
    w = old_w;
    for (int i = 0; i < `SBSA_LANES; i++) begin
      if (!b.bw[i]) begin
        w[i*`SBSA_LANE_W +: `SBSA_LANE_W] = b.data[i*`SBSA_LANE_W +: `SBSA_LANE_W];
        w[`SBSA_DATA_W + i]               = b.par[i];
      end
    end
    return w;
  endfunction : sbsa_merge

  // Only the second stage of the sleep synchroniser is read
  assign sleep_on = st_r.sleep_s2;
  assign cs_all   = !chip_select_low_first && chip_select_high_active
                    && !chip_select_low_second;
  assign bw_any   = (byte_write_select_n != `SBSA_BW_NONE);

  // A full buffer stalls the edge like the qualifier would; the host cannot see it
  assign edge_go  = !clock_qualify_n && !sleep_on
                    && (wbuf_in_ready || !st_r.wr_pend);
  assign load_go  = edge_go && !advance_or_load && cs_all;
  assign capture  = st_r.wr_pend && edge_go;

  assign beat_nxt = `SBSA_BURST_W'(st_r.beat + `SBSA_BEAT_STEP);

  sbsa_burst_order #(
    .LO_W       (`SBSA_BURST_W)
  ) u_order (
    .start_lo   (st_r.base[`SBSA_BURST_W-1:0]),
    .beat       (beat_nxt),
    .interleave (st_r.mode_s2),
    .lo         (lo_cont)
  );

  assign addr_cont = {st_r.base[`SBSA_ADDR_W-1:`SBSA_BURST_W], lo_cont};
  assign rd_addr   = load_go ? addr_in : addr_cont;

  assign beat_in.addr = st_r.wr_addr;
  assign beat_in.bw   = st_r.wr_bw;
  assign beat_in.data = data_pins_in;
  assign beat_in.par  = parity_lane_pins_in;

  // Bypass the buffer when empty so a read right after a write sees new data
  assign wbuf_in_valid  = capture && wbuf_out_valid;
  assign wbuf_out_ready = !sleep_on;
  assign mw_en          = (wbuf_out_valid && !sleep_on) || (capture && !wbuf_out_valid);
  assign mw_beat        = wbuf_out_valid ? wbuf_out : beat_in;

  assign rd_word = (capture && beat_in.addr == rd_addr)
                   ? sbsa_merge(mem[rd_addr], beat_in) : mem[rd_addr];

  sbsa_wbuf #(
    .WIDTH     ($bits(sbsa_pkg::sbsa_beat_t)),
    .DEPTH     (WBUF_DEPTH)
  ) u_wbuf (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (wbuf_in_valid),
    .in_ready  (wbuf_in_ready),
    .in_data   (beat_in),
    .out_valid (wbuf_out_valid),
    .out_ready (wbuf_out_ready),
    .out_data  (wbuf_out)
  );

  always_comb begin
    st_nxt          = st_r;
    st_nxt.sleep_s1 = sleep_request;
    st_nxt.sleep_s2 = st_r.sleep_s1;
    st_nxt.mode_s1  = burst_order;
    st_nxt.mode_s2  = st_r.mode_s1;
    if (sleep_on) begin
      // Pending beats are dropped; sleep is entered deselected
      st_nxt.phase    = sbsa_pkg::SBSA_DESEL;
      st_nxt.wr_pend  = 1'b0;
      st_nxt.rd_drive = 1'b0;
    end else if (edge_go) begin
      st_nxt.wr_pend  = 1'b0;
      st_nxt.rd_drive = 1'b0;
      if (!advance_or_load) begin
        if (cs_all) begin
          st_nxt.base = addr_in;
          st_nxt.beat = `SBSA_BEAT_FIRST;
          if (write_strobe_n) begin
            st_nxt.phase    = sbsa_pkg::SBSA_READ;
            st_nxt.rd_drive = 1'b1;
          end else begin
            st_nxt.phase   = sbsa_pkg::SBSA_WRITE;
            st_nxt.wr_pend = bw_any;
            st_nxt.wr_addr = addr_in;
            st_nxt.wr_bw   = byte_write_select_n;
          end
        end else begin
          st_nxt.phase = sbsa_pkg::SBSA_DESEL;
        end
      end else begin
        unique case (st_r.phase)
          sbsa_pkg::SBSA_DESEL: begin
            st_nxt.phase = sbsa_pkg::SBSA_DESEL;
          end
          sbsa_pkg::SBSA_READ: begin
            st_nxt.beat     = beat_nxt;
            st_nxt.rd_drive = 1'b1;
          end
          sbsa_pkg::SBSA_WRITE: begin
            st_nxt.beat    = beat_nxt;
            st_nxt.wr_pend = bw_any;
            st_nxt.wr_addr = addr_cont;
            st_nxt.wr_bw   = byte_write_select_n;
          end
          default: begin
            st_nxt.phase = sbsa_pkg::SBSA_DESEL;
          end
        endcase
      end
      if (st_nxt.rd_drive) begin
        st_nxt.rd_par  = rd_word[`SBSA_WORD_W-1:`SBSA_DATA_W];
        st_nxt.rd_data = rd_word[`SBSA_DATA_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Beats without a selected byte never reach this port
  always_ff @(posedge clk) begin
    if (mw_en) begin
      mem[mw_beat.addr] <= sbsa_merge(mem[mw_beat.addr], mw_beat);
    end
  end

  assign data_pins_out        = st_r.rd_data;
  assign parity_lane_pins_out = st_r.rd_par;
  // Output enable is asynchronous by design, so this one output is gated, not registered
  assign dq_oe_n = !(st_r.rd_drive && !out_enable_n && !sleep_on);

  a_read_start: assert property (
    @(posedge clk) disable iff (srst)
    load_go && write_strobe_n |=> st_r.phase == sbsa_pkg::SBSA_READ
      && st_r.rd_drive && st_r.base == $past(addr_in))
    else $error("read start not loaded");

  a_read_advance: assert property (
    @(posedge clk) disable iff (srst)
    edge_go && advance_or_load && st_r.phase == sbsa_pkg::SBSA_READ
    |=> st_r.rd_drive && st_r.beat == `SBSA_BURST_W'($past(st_r.beat) + `SBSA_BEAT_STEP))
    else $error("read burst did not advance");

  a_dummy_start: assert property (
    @(posedge clk) disable iff (srst)
    load_go && write_strobe_n ##1 out_enable_n |-> dq_oe_n)
    else $error("dummy read drove pins");

  a_dummy_cont: assert property (
    @(posedge clk) disable iff (srst)
    edge_go && advance_or_load && st_r.phase == sbsa_pkg::SBSA_READ ##1 out_enable_n
    |-> dq_oe_n && st_r.phase == sbsa_pkg::SBSA_READ)
    else $error("dummy continue drove pins");

  a_write_start: assert property (
    @(posedge clk) disable iff (srst)
    load_go && !write_strobe_n && bw_any |=> st_r.phase == sbsa_pkg::SBSA_WRITE
      && st_r.wr_pend && st_r.wr_addr == $past(addr_in))
    else $error("write start not loaded");

  a_write_cont: assert property (
    @(posedge clk) disable iff (srst)
    edge_go && advance_or_load && st_r.phase == sbsa_pkg::SBSA_WRITE && bw_any
    |=> st_r.wr_pend && st_r.wr_bw == $past(byte_write_select_n))
    else $error("write burst beat lost");

  a_abort_start: assert property (
    @(posedge clk) disable iff (srst)
    load_go && !write_strobe_n && !bw_any |=> !st_r.wr_pend && dq_oe_n)
    else $error("write abort stored data");

  a_abort_cont: assert property (
    @(posedge clk) disable iff (srst)
    edge_go && advance_or_load && st_r.phase == sbsa_pkg::SBSA_WRITE && !bw_any
    |=> !st_r.wr_pend && st_r.beat == `SBSA_BURST_W'($past(st_r.beat) + `SBSA_BEAT_STEP))
    else $error("abort continue wrong");

  a_stall_hold: assert property (
    @(posedge clk) disable iff (srst)
    clock_qualify_n && !sleep_on |=> st_r.phase == $past(st_r.phase)
      && st_r.beat == $past(st_r.beat) && st_r.wr_pend == $past(st_r.wr_pend)
      && st_r.rd_data == $past(st_r.rd_data))
    else $error("stalled edge changed state");

  a_write_tri: assert property (
    @(posedge clk) disable iff (srst)
    st_r.phase == sbsa_pkg::SBSA_WRITE |-> dq_oe_n)
    else $error("pins driven in write");

  a_oe_follow: assert property (
    @(posedge clk) disable iff (srst)
    st_r.rd_drive && !sleep_on |-> dq_oe_n == out_enable_n)
    else $error("pins do not follow enable");

  a_reset_idle: assert property (
    @(posedge clk)
    srst |=> st_r.phase == sbsa_pkg::SBSA_DESEL && dq_oe_n && !st_r.wr_pend)
    else $error("not deselected after reset");

  a_no_byte: assert property (
    @(posedge clk) disable iff (srst)
    mw_en |-> mw_beat.bw != `SBSA_BW_NONE)
    else $error("write without byte select");

  a_deselect_now: assert property (
    @(posedge clk) disable iff (srst)
    edge_go && !advance_or_load && !cs_all |=> st_r.phase == sbsa_pkg::SBSA_DESEL && dq_oe_n)
    else $error("deselect not taken");

  a_data_edge: assert property (
    @(posedge clk) disable iff (srst)
    st_r.wr_pend && edge_go && st_r.wr_bw == '0 && !wbuf_out_valid
    |=> mem[$past(st_r.wr_addr)] == $past({parity_lane_pins_in, data_pins_in}))
    else $error("write data not taken");

  a_interleave: assert property (
    @(posedge clk) disable iff (srst)
    st_r.mode_s2 && !load_go |-> rd_addr[`SBSA_BURST_W-1:0]
      == (st_r.base[`SBSA_BURST_W-1:0] ^ beat_nxt))
    else $error("interleaved order wrong");

  a_sleep_enter: assert property (
    @(posedge clk) disable iff (srst)
    sleep_request [*3] |-> dq_oe_n ##1 (st_r.phase == sbsa_pkg::SBSA_DESEL && !st_r.wr_pend))
    else $error("sleep not entered");

  a_read_only_drive: assert property (
    @(posedge clk) disable iff (srst)
    st_r.phase != sbsa_pkg::SBSA_READ |-> dq_oe_n)
    else $error("pins driven outside a read");

  a_desel_cont: assert property (
    @(posedge clk) disable iff (srst)
    edge_go && advance_or_load && st_r.phase == sbsa_pkg::SBSA_DESEL
    |=> st_r.phase == sbsa_pkg::SBSA_DESEL && dq_oe_n)
    else $error("advance left deselect");

  a_lane_write: assert property (
    @(posedge clk) disable iff (srst)
    mw_en && !mw_beat.bw[0] |=> mem[$past(mw_beat.addr)][`SBSA_LANE_W-1:0]
      == $past(mw_beat.data[`SBSA_LANE_W-1:0]) && mem[$past(mw_beat.addr)][`SBSA_DATA_W]
      == $past(mw_beat.par[0]))
    else $error("selected lane not written");

  // Lane one is checked because the partial burst leaves it unselected
  a_lane_keep: assert property (
    @(posedge clk) disable iff (srst)
    mw_en && mw_beat.bw[1]
    |=> mem[$past(mw_beat.addr)][`SBSA_LANE_W +: `SBSA_LANE_W]
      == $past(mem[mw_beat.addr][`SBSA_LANE_W +: `SBSA_LANE_W]))
    else $error("unselected lane altered");

endmodule : sbsa_core
`default_nettype wire

/* verification/sbsa_host_model.sv */
// Host controller model that drives the burst SRAM bus
`default_nettype none
`include "sbsa_regs.svh"
module sbsa_host_model (
  input  wire logic                    clk,
  output logic                         chip_select_low_first,
  output logic                         chip_select_high_active,
  output logic                         chip_select_low_second,
  output logic                         advance_or_load,
  output logic                         write_strobe_n,
  output logic [`SBSA_LANES-1:0]       byte_write_select_n,
  output logic                         clock_qualify_n,
  output logic                         sleep_request,
  output logic                         burst_order,
  output logic                         out_enable_n,
  output logic [`SBSA_ADDR_W-1:0]      addr_in,
  output logic [`SBSA_DATA_W-1:0]      data_pins_in,
  output logic [`SBSA_LANES-1:0]       parity_lane_pins_in
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    {chip_select_low_first, chip_select_high_active, chip_select_low_second} = 3'h5;
    {advance_or_load, write_strobe_n, clock_qualify_n} = 3'h2;
    {sleep_request, burst_order, out_enable_n} = 3'h0;
    byte_write_select_n = 4'hf;
    addr_in = '0;
    {parity_lane_pins_in, data_pins_in} = '0;
  end

  // One bus cycle; unused address and data lines toggle so stale values never match
  task automatic step(input logic ld, input logic sel, input logic we, input logic [3:0] bw,
                      input logic [17:0] a, input logic dv, input logic [35:0] d);
    @(negedge clk);
    clock_qualify_n = 1'b0;
    advance_or_load = !ld;
    chip_select_low_first = !sel;
    chip_select_high_active = sel;
    chip_select_low_second = !sel;
    write_strobe_n = we;
    byte_write_select_n = bw;
    addr_in = ld ? a : ~addr_in;
    {parity_lane_pins_in, data_pins_in} = dv ? d : ~{parity_lane_pins_in, data_pins_in};
  endtask : step

  task automatic stall();
    @(negedge clk);
    clock_qualify_n = 1'b1;
  endtask : stall

  // Deselects first, so sleep entry and recovery never see an active load
  task automatic misc(input logic oe_n, input logic slp, input logic ord);
    @(negedge clk);
    clock_qualify_n = 1'b0;
    advance_or_load = 1'b0;
    chip_select_low_first = 1'b1;
    out_enable_n = oe_n;
    sleep_request = slp;
    burst_order = ord;
  endtask : misc
endmodule : sbsa_host_model
`default_nettype wire

/* verification/sbsa_core_tb_top.sv */
// Self-checking bench for the burst SRAM access core
`default_nettype none
`include "sbsa_regs.svh"
module sbsa_core_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic                    clk;
  logic                    srst;
  logic                    chip_select_low_first;
  logic                    chip_select_high_active;
  logic                    chip_select_low_second;
  logic                    advance_or_load;
  logic                    write_strobe_n;
  logic [`SBSA_LANES-1:0]  byte_write_select_n;
  logic                    clock_qualify_n;
  logic                    sleep_request;
  logic                    burst_order;
  logic                    out_enable_n;
  logic [`SBSA_ADDR_W-1:0] addr_in;
  logic [`SBSA_DATA_W-1:0] data_pins_in;
  logic [`SBSA_LANES-1:0]  parity_lane_pins_in;
  logic [`SBSA_DATA_W-1:0] data_pins_out;
  logic [`SBSA_LANES-1:0]  parity_lane_pins_out;
  logic                    dq_oe_n;
  int                      miscompares = 0;
  int                      n_tests = 0;
  int                      cycles = 0;
  logic [35:0]             mem [logic [17:0]];

  sbsa_host_model host (
    .clk, .chip_select_low_first, .chip_select_high_active, .chip_select_low_second,
    .advance_or_load, .write_strobe_n, .byte_write_select_n, .clock_qualify_n,
    .sleep_request, .burst_order, .out_enable_n, .addr_in, .data_pins_in,
    .parity_lane_pins_in
  );

  sbsa_core #(.WBUF_DEPTH(`SBSA_WBUF_DEPTH)) uut (
    .clk, .srst, .chip_select_low_first, .chip_select_high_active, .chip_select_low_second,
    .advance_or_load, .write_strobe_n, .byte_write_select_n, .clock_qualify_n,
    .sleep_request, .burst_order, .out_enable_n, .addr_in, .data_pins_in,
    .parity_lane_pins_in, .data_pins_out, .parity_lane_pins_out, .dq_oe_n
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string w, input logic [35:0] e, input logic [35:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask : check

  task automatic chk1(input string w, input logic e, input logic g);
    check(w, {35'h0, e}, {35'h0, g});
  endtask : chk1

  // Outputs are sampled 1 ns after the edge so registered values have settled
  task automatic go(input logic ld, input logic sel, input logic we, input logic [3:0] bw,
                    input logic [17:0] a, input logic dv, input logic [35:0] d);
    host.step(ld, sel, we, bw, a, dv, d);
    @(posedge clk);
    #1;
  endtask : go

  function automatic logic [17:0] ba(input logic [17:0] b, input logic [1:0] k, input logic il);
    return {b[17:2], il ? (b[1:0] ^ k) : (b[1:0] + k)};
  endfunction : ba

  task automatic put(input logic [17:0] a, input logic [3:0] bw, input logic [35:0] d);
    logic [35:0] w;
    w = mem.exists(a) ? mem[a] : '0;
    for (int i = 0; i < 4; i++) begin
      if (!bw[i]) begin
        w[8*i +: 8] = d[8*i +: 8];
        w[32 + i] = d[32 + i];
      end
    end
    mem[a] = w;
  endtask : put

  task automatic wr_burst(input logic [17:0] b, input logic [3:0] bw, input logic [35:0] s);
    logic [35:0] d;
    go(1'b1, 1'b1, 1'b0, bw, b, 1'b0, '0);
    for (int k = 0; k < 4; k++) begin
      chk1("write_oe_n", 1'b1, dq_oe_n);
      d = {s[35:32] ^ 4'(k), s[31:0] + 32'h0101_0101 * 32'(k)};
      put(ba(b, 2'(k), 1'b0), bw, d);
      go(k == 3, 1'b0, 1'b0, bw, b, 1'b1, d);
    end
  endtask : wr_burst

  task automatic rd_burst(input logic [17:0] b, input logic il, input logic oe);
    logic [35:0] e;
    host.misc(oe, 1'b0, il);
    repeat (2) @(posedge clk);
    go(1'b1, 1'b1, 1'b1, 4'hf, b, 1'b0, '0);
    for (int k = 0; k < 4; k++) begin
      e = mem[ba(b, 2'(k), il)];
      chk1("read_oe_n", oe, dq_oe_n);
      if (!oe) check("read_word", e, {parity_lane_pins_out, data_pins_out});
      if (k == 1 && !oe) begin
        host.out_enable_n = 1'b1;
        #0.5;
        chk1("oe_off", 1'b1, dq_oe_n);
        host.out_enable_n = 1'b0;
        #0.5;
        chk1("oe_on", 1'b0, dq_oe_n);
      end
      if (k == 2 && !oe) begin
        host.stall();
        @(posedge clk);
        #1;
        check("stall_hold", e, {parity_lane_pins_out, data_pins_out});
      end
      go(k == 3, 1'b0, 1'b1, 4'hf, b, 1'b0, '0);
    end
    chk1("desel_oe_n", 1'b1, dq_oe_n);
    // An advance while deselected must not reopen the burst
    go(1'b0, 1'b0, 1'b1, 4'hf, b, 1'b0, '0);
    chk1("desel_cont_oe_n", 1'b1, dq_oe_n);
  endtask : rd_burst

  task automatic sleep_test();
    host.misc(1'b0, 1'b1, 1'b0);
    repeat (2) @(posedge clk);
    go(1'b1, 1'b1, 1'b1, 4'hf, 18'h0_0100, 1'b0, '0);
    chk1("sleep_oe_n", 1'b1, dq_oe_n);
    host.misc(1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
  endtask : sleep_test

  initial begin
    srst = 1'b1;
    repeat (10) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    @(posedge clk);
    #1;
    chk1("reset_oe_n", 1'b1, dq_oe_n);
    // Start at offset 2 so the linear burst wraps inside the four-beat block
    wr_burst(18'h0_0102, 4'h0, 36'h1_2345_6789);
    rd_burst(18'h0_0101, 1'b0, 1'b0);
    wr_burst(18'h0_0100, 4'ha, 36'h9_8765_4321);
    wr_burst(18'h0_0102, 4'hf, 36'hf_0f0f_0f0f);
    rd_burst(18'h0_0100, 1'b0, 1'b0);
    rd_burst(18'h0_0100, 1'b0, 1'b1);
    rd_burst(18'h0_0101, 1'b1, 1'b0);
    sleep_test();
    rd_burst(18'h0_0103, 1'b0, 1'b0);
    give_verdict();
  end
endmodule : sbsa_core_tb_top
`default_nettype wire
